// ===== src/tlmh_pkg.sv
`default_nettype none
package tlmh_pkg;
  // ==========================================================
  // channel opcodes
  localparam logic [2:0] A_PUT_FULL   = 3'h0;
  localparam logic [2:0] A_PUT_PART   = 3'h1;
  localparam logic [2:0] A_ARITH      = 3'h2;
  localparam logic [2:0] A_LOGIC      = 3'h3;
  localparam logic [2:0] A_GET        = 3'h4;
  localparam logic [2:0] A_HINT       = 3'h5;
  localparam logic [2:0] D_ACK        = 3'h0;
  localparam logic [2:0] D_ACK_DATA   = 3'h1;
  localparam logic [2:0] D_HINT_ACK   = 3'h2;
  // ==========================================================
  // atomic_op_codes and hint_kinds
  localparam logic [2:0] ATOM_MIN     = 3'h0;
  localparam logic [2:0] ATOM_MAX     = 3'h1;
  localparam logic [2:0] ATOM_MINU    = 3'h2;
  localparam logic [2:0] ATOM_MAXU    = 3'h3;
  localparam logic [2:0] ATOM_ADD     = 3'h4;
  localparam logic [2:0] ATOM_XOR     = 3'h0;
  localparam logic [2:0] ATOM_OR      = 3'h1;
  localparam logic [2:0] ATOM_AND     = 3'h2;
  localparam logic [2:0] ATOM_SWAP    = 3'h3;
  localparam logic [2:0] HINT_SHARED  = 3'h0;
  localparam logic [2:0] HINT_EXCL    = 3'h1;
  // ==========================================================
  // request kinds at the builder port
  localparam logic [2:0] REQ_GET      = 3'h0;
  localparam logic [2:0] REQ_PUT      = 3'h1;
  localparam logic [2:0] REQ_ARITH    = 3'h2;
  localparam logic [2:0] REQ_LOGIC    = 3'h3;
  localparam logic [2:0] REQ_HINT     = 3'h4;
  // ==========================================================
  // reset values and field widths
  localparam int unsigned SIZE_W      = 4;
  localparam logic [7:0]  BEAT_IDX_RST = 8'h00;

  function automatic logic a_has_data(input logic [2:0] opc);
    return (opc == A_PUT_FULL) || (opc == A_PUT_PART) || (opc == A_ARITH) || (opc == A_LOGIC);
  endfunction

  function automatic logic d_has_data(input logic [2:0] opc);
    return opc == D_ACK_DATA;
  endfunction

  // beats minus one; one beat when no payload or size fits a beat
  function automatic logic [15:0] beats_m1(input logic has, input logic [3:0] size, input logic [3:0] lg_beat);
    logic [15:0] r;
    r = 16'h0000;
    if (has && (size > lg_beat)) begin
      r = (16'h0001 << (size - lg_beat)) - 16'h0001;
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// ===== src/tlmh_beat_tracker.sv
`timescale 1ns/1ns
`default_nettype none
module tlmh_beat_tracker #(
  parameter bit          IS_D    = 1'b0,
  parameter logic [3:0]  LG_BEAT = 4'h3,
  parameter int unsigned CNT_W   = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic             valid,
  input  wire logic             ready,
  input  wire logic [2:0]       opcode,
  input  wire logic [3:0]       log2_size,
  output logic                  first,
  output logic                  last,
  output logic                  done,
  output logic [CNT_W-1:0]      count,
  output logic [CNT_W-1:0]      beat_total,
  output logic [CNT_W-1:0]      beat_total_minus_one,
  output logic                  carries_payload
);
  typedef struct packed {
    logic [CNT_W-1:0] idx;
  } tlmh_trk_t;

  tlmh_trk_t st_r;
  tlmh_trk_t st_nxt;
  logic      fire;
  logic [15:0] m1;

  // ==========================================================
  // header decode
  // header fields are trusted constant across beats, only data may move
  assign carries_payload = IS_D ? tlmh_pkg::d_has_data(opcode) : tlmh_pkg::a_has_data(opcode);
  assign m1 = tlmh_pkg::beats_m1(carries_payload, log2_size, LG_BEAT);
  assign beat_total_minus_one = m1[CNT_W-1:0];
  assign beat_total = beat_total_minus_one + CNT_W'(1);
  assign fire  = valid && ready;
  assign count = st_r.idx;
  assign first = (st_r.idx == '0);
  assign last  = (st_r.idx == beat_total_minus_one);
  assign done  = fire && last;

  // ==========================================================
  // beat index
  always_comb begin
    st_nxt = st_r;
    if (fire) begin
      st_nxt.idx = last ? '0 : st_r.idx + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r.idx <= tlmh_pkg::BEAT_IDX_RST[CNT_W-1:0];
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  first_beat_a: assert property (@(posedge clk_sys) disable iff (srst)
    (fire && last && ce) |=> first)
    else $error("first flag missing after final beat");
  last_beat_a: assert property (@(posedge clk_sys) disable iff (srst)
    (fire && ce && !last && (beat_total_minus_one == CNT_W'(1)) && first) |=> last)
    else $error("last flag missing on second of two beats");
  done_beat_a: assert property (@(posedge clk_sys) disable iff (srst)
    done |-> (valid && ready && last))
    else $error("done without a final transfer");
  count_step_a: assert property (@(posedge clk_sys) disable iff (srst)
    (fire && ce && !last) |=> (count == $past(count) + CNT_W'(1)))
    else $error("beat index did not advance");
  reset_idx_a: assert property (@(posedge clk_sys)
    srst |=> (first && (count == '0)))
    else $error("beat index not cleared by reset");
  cv_multi_done: cover property (@(posedge clk_sys) disable iff (srst)
    done && (count != '0));
endmodule
`default_nettype wire

// ===== src/tlmh_edge_helper.sv
// Operation
// - get answered by data ack, maybe multibeat
// - each built request carries a legality flag
// - size field holds log2 of bytes
// - mask given gives partial put, else full
// - write answered by exactly one plain ack
// - arithmetic atomics min max minu maxu add
// - logical atomics xor or and swap
// - request data is the right operand
// - hint kind selects shared or exclusive prefetch
// - hints always answered with hint ack
// - data given gives data ack, else ack
// - first flag on opening beat
// - last flag on final beat
// - done only on transferred final beat
// - beat index counts from zero
// - beat count and count minus one
// - payload flag for data-bearing opcodes
`timescale 1ns/1ns
`default_nettype none
module tlmh_edge_helper #(
  parameter int unsigned SRC_W       = 4,
  parameter int unsigned ADDR_W      = 32,
  parameter int unsigned DATA_W      = 64,
  parameter logic [3:0]  LG_BEAT     = 4'h3,
  parameter int unsigned CNT_W       = 8,
  parameter logic [3:0]  MAX_LG_GET  = 4'h6,
  parameter logic [3:0]  MAX_LG_PUT  = 4'h6,
  parameter logic [3:0]  MAX_LG_ATOM = 4'h3,
  parameter logic [3:0]  MAX_LG_HINT = 4'h6
) (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              ce,
  // request builder
  input  wire logic              req_valid,
  input  wire logic [2:0]        req_kind,
  input  wire logic [SRC_W-1:0]  req_source_id,
  input  wire logic [ADDR_W-1:0] req_target_address,
  input  wire logic [3:0]        req_log2_size,
  input  wire logic [DATA_W-1:0] req_data,
  input  wire logic              req_mask_given,
  input  wire logic [DATA_W/8-1:0] req_mask,
  input  wire logic [2:0]        req_param,
  output logic                   a_valid,
  output logic                   a_legal,
  output logic [2:0]             a_opcode,
  output logic [2:0]             a_param,
  output logic [3:0]             a_size,
  output logic [SRC_W-1:0]       a_source,
  output logic [ADDR_W-1:0]      a_address,
  output logic [DATA_W/8-1:0]    a_mask,
  output logic [DATA_W-1:0]      a_data,
  // acknowledgement builder
  input  wire logic              ack_valid,
  input  wire logic [2:0]        ack_a_opcode,
  input  wire logic [3:0]        ack_a_size,
  input  wire logic [SRC_W-1:0]  ack_a_source,
  input  wire logic              ack_data_given,
  input  wire logic [DATA_W-1:0] ack_data,
  output logic                   d_valid,
  output logic [2:0]             d_opcode,
  output logic [3:0]             d_size,
  output logic [SRC_W-1:0]       d_source,
  output logic [DATA_W-1:0]      d_data,
  output logic                   d_mismatch,
  // monitored A channel
  input  wire logic              mon_a_valid,
  input  wire logic              mon_a_ready,
  input  wire logic [2:0]        mon_a_opcode,
  input  wire logic [3:0]        mon_a_size,
  output logic                   mon_a_first,
  output logic                   mon_a_last,
  output logic                   mon_a_done,
  output logic [CNT_W-1:0]       mon_a_count,
  output logic [CNT_W-1:0]       mon_a_beat_total,
  output logic [CNT_W-1:0]       mon_a_beat_total_minus_one,
  output logic                   mon_a_carries_payload,
  // monitored D channel
  input  wire logic              mon_d_valid,
  input  wire logic              mon_d_ready,
  input  wire logic [2:0]        mon_d_opcode,
  input  wire logic [3:0]        mon_d_size,
  output logic                   mon_d_first,
  output logic                   mon_d_last,
  output logic                   mon_d_done,
  output logic [CNT_W-1:0]       mon_d_count,
  output logic [CNT_W-1:0]       mon_d_beat_total,
  output logic [CNT_W-1:0]       mon_d_beat_total_minus_one,
  output logic                   mon_d_carries_payload
);
  localparam int unsigned MASK_W = DATA_W / 8;

  typedef struct packed {
    logic              a_vld;
    logic              a_legal;
    logic [2:0]        a_opc;
    logic [2:0]        a_prm;
    logic [3:0]        a_size;
    logic [SRC_W-1:0]  a_src;
    logic [ADDR_W-1:0] a_addr;
    logic [MASK_W-1:0] a_mask;
    logic [DATA_W-1:0] a_data;
    logic              d_vld;
    logic [2:0]        d_opc;
    logic [3:0]        d_size;
    logic [SRC_W-1:0]  d_src;
    logic [DATA_W-1:0] d_data;
    logic              d_mis;
  } tlmh_state_t;

  tlmh_state_t st_r;
  tlmh_state_t st_nxt;

  // ==========================================================
  // helpers
  // lanes covered by an aligned window of 2^size bytes within one beat
  function automatic logic [MASK_W-1:0] size_mask(input logic [ADDR_W-1:0] addr, input logic [3:0] size);
    logic [MASK_W-1:0] m;
    logic [ADDR_W-1:0] win;
    m = '0;
    win = ~((ADDR_W'(1) << size) - ADDR_W'(1));
    for (int i = 0; i < MASK_W; i++) begin
      m[i] = (size >= LG_BEAT) || ((ADDR_W'(i) & win) == (addr & win & ADDR_W'(MASK_W - 1)));
    end
    return m;
  endfunction

  // legal when kind and code exist, size within limit and address aligned
  function automatic logic req_legal(input logic [2:0] kind, input logic [3:0] size,
                                     input logic [ADDR_W-1:0] addr, input logic [2:0] prm);
    logic ok;
    logic aligned;
    aligned = (addr & ((ADDR_W'(1) << size) - ADDR_W'(1))) == '0;
    unique case (kind)
      tlmh_pkg::REQ_GET:   ok = size <= MAX_LG_GET;
      tlmh_pkg::REQ_PUT:   ok = size <= MAX_LG_PUT;
      tlmh_pkg::REQ_ARITH: ok = (size <= MAX_LG_ATOM) && (prm <= tlmh_pkg::ATOM_ADD);
      tlmh_pkg::REQ_LOGIC: ok = (size <= MAX_LG_ATOM) && (prm <= tlmh_pkg::ATOM_SWAP);
      tlmh_pkg::REQ_HINT:  ok = (size <= MAX_LG_HINT) && (prm <= tlmh_pkg::HINT_EXCL);
      default:             ok = 1'b0;
    endcase
    return ok && aligned;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.a_vld = req_valid;
    st_nxt.d_vld = ack_valid;
    if (req_valid) begin
      st_nxt.a_legal = req_legal(req_kind, req_log2_size, req_target_address, req_param);
      st_nxt.a_size  = req_log2_size;
      st_nxt.a_src   = req_source_id;
      st_nxt.a_addr  = req_target_address;
      st_nxt.a_mask  = size_mask(req_target_address, req_log2_size);
      st_nxt.a_data  = '0;
      st_nxt.a_prm   = 3'h0;
      unique case (req_kind)
        tlmh_pkg::REQ_PUT: begin
          // partial only when the caller supplies lanes
          st_nxt.a_opc  = req_mask_given ? tlmh_pkg::A_PUT_PART : tlmh_pkg::A_PUT_FULL;
          st_nxt.a_mask = req_mask_given ? req_mask : st_nxt.a_mask;
          st_nxt.a_data = req_data;
        end
        tlmh_pkg::REQ_ARITH: begin
          st_nxt.a_opc  = tlmh_pkg::A_ARITH;
          st_nxt.a_prm  = req_param;
          st_nxt.a_data = req_data;
        end
        tlmh_pkg::REQ_LOGIC: begin
          st_nxt.a_opc  = tlmh_pkg::A_LOGIC;
          st_nxt.a_prm  = req_param;
          st_nxt.a_data = req_data;
        end
        tlmh_pkg::REQ_HINT: begin
          st_nxt.a_opc = tlmh_pkg::A_HINT;
          st_nxt.a_prm = req_param;
        end
        default: begin
          // get, and unknown kinds which are flagged illegal
          st_nxt.a_opc = tlmh_pkg::A_GET;
        end
      endcase
    end
    if (ack_valid) begin
      st_nxt.d_size = ack_a_size;
      st_nxt.d_src  = ack_a_source;
      st_nxt.d_data = ack_data_given ? ack_data : '0;
      if (ack_a_opcode == tlmh_pkg::A_HINT) begin
        st_nxt.d_opc = tlmh_pkg::D_HINT_ACK;
        st_nxt.d_mis = ack_data_given;
      end else begin
        st_nxt.d_opc = ack_data_given ? tlmh_pkg::D_ACK_DATA : tlmh_pkg::D_ACK;
        // gets and atomics need data back, puts need a bare ack
        st_nxt.d_mis = ack_data_given != ((ack_a_opcode == tlmh_pkg::A_GET) ||
                       (ack_a_opcode == tlmh_pkg::A_ARITH) || (ack_a_opcode == tlmh_pkg::A_LOGIC));
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign a_valid    = st_r.a_vld;
  assign a_legal    = st_r.a_legal;
  assign a_opcode   = st_r.a_opc;
  assign a_param    = st_r.a_prm;
  assign a_size     = st_r.a_size;
  assign a_source   = st_r.a_src;
  assign a_address  = st_r.a_addr;
  assign a_mask     = st_r.a_mask;
  assign a_data     = st_r.a_data;
  assign d_valid    = st_r.d_vld;
  assign d_opcode   = st_r.d_opc;
  assign d_size     = st_r.d_size;
  assign d_source   = st_r.d_src;
  assign d_data     = st_r.d_data;
  assign d_mismatch = st_r.d_mis;

  // ==========================================================
  // beat trackers, one per monitored channel
  tlmh_beat_tracker #(
    .IS_D    (1'b0),
    .LG_BEAT (LG_BEAT),
    .CNT_W   (CNT_W)
  ) u_trk_a (
    .clk_sys              (clk_sys),
    .srst                 (srst),
    .ce                   (ce),
    .valid                (mon_a_valid),
    .ready                (mon_a_ready),
    .opcode               (mon_a_opcode),
    .log2_size            (mon_a_size),
    .first                (mon_a_first),
    .last                 (mon_a_last),
    .done                 (mon_a_done),
    .count                (mon_a_count),
    .beat_total           (mon_a_beat_total),
    .beat_total_minus_one (mon_a_beat_total_minus_one),
    .carries_payload      (mon_a_carries_payload)
  );

  tlmh_beat_tracker #(
    .IS_D    (1'b1),
    .LG_BEAT (LG_BEAT),
    .CNT_W   (CNT_W)
  ) u_trk_d (
    .clk_sys              (clk_sys),
    .srst                 (srst),
    .ce                   (ce),
    .valid                (mon_d_valid),
    .ready                (mon_d_ready),
    .opcode               (mon_d_opcode),
    .log2_size            (mon_d_size),
    .first                (mon_d_first),
    .last                 (mon_d_last),
    .done                 (mon_d_done),
    .count                (mon_d_count),
    .beat_total           (mon_d_beat_total),
    .beat_total_minus_one (mon_d_beat_total_minus_one),
    .carries_payload      (mon_d_carries_payload)
  );

  // ==========================================================
  // checks
  legal_flag_a: assert property (@(posedge clk_sys) disable iff (srst)
    (req_valid && ce && (req_kind == tlmh_pkg::REQ_GET) && (req_log2_size > MAX_LG_GET)) |=> !a_legal)
    else $error("oversized get reported legal");
  size_field_a: assert property (@(posedge clk_sys) disable iff (srst)
    (req_valid && ce) |=> (a_valid && (a_size == $past(req_log2_size))))
    else $error("size field not log2 of request");
  put_kind_a: assert property (@(posedge clk_sys) disable iff (srst)
    (req_valid && ce && (req_kind == tlmh_pkg::REQ_PUT)) |=>
    (a_opcode == ($past(req_mask_given) ? tlmh_pkg::A_PUT_PART : tlmh_pkg::A_PUT_FULL)))
    else $error("put encoded with wrong opcode");
  arith_code_a: assert property (@(posedge clk_sys) disable iff (srst)
    (req_valid && ce && (req_kind == tlmh_pkg::REQ_ARITH)) |=>
    ((a_opcode == tlmh_pkg::A_ARITH) && (a_param == $past(req_param))))
    else $error("arithmetic request misencoded");
  logic_code_a: assert property (@(posedge clk_sys) disable iff (srst)
    (req_valid && ce && (req_kind == tlmh_pkg::REQ_LOGIC)) |=>
    ((a_opcode == tlmh_pkg::A_LOGIC) && (a_param == $past(req_param))))
    else $error("logical request misencoded");
  atom_operand_a: assert property (@(posedge clk_sys) disable iff (srst)
    (req_valid && ce && ((req_kind == tlmh_pkg::REQ_ARITH) || (req_kind == tlmh_pkg::REQ_LOGIC)))
    |=> (a_data == $past(req_data)))
    else $error("atomic operand not passed through");
  hint_kind_a: assert property (@(posedge clk_sys) disable iff (srst)
    (req_valid && ce && (req_kind == tlmh_pkg::REQ_HINT)) |=>
    ((a_opcode == tlmh_pkg::A_HINT) && (a_param == $past(req_param)) && !carries(a_opcode)))
    else $error("hint misencoded");
  hint_ack_a: assert property (@(posedge clk_sys) disable iff (srst)
    (ack_valid && ce && (ack_a_opcode == tlmh_pkg::A_HINT)) |=> (d_opcode == tlmh_pkg::D_HINT_ACK))
    else $error("hint not answered with hint ack");
  ack_kind_a: assert property (@(posedge clk_sys) disable iff (srst)
    (ack_valid && ce && (ack_a_opcode != tlmh_pkg::A_HINT)) |=>
    (d_opcode == ($past(ack_data_given) ? tlmh_pkg::D_ACK_DATA : tlmh_pkg::D_ACK)))
    else $error("ack kind does not follow data presence");
  put_ack_a: assert property (@(posedge clk_sys) disable iff (srst)
    (ack_valid && ce && !ack_data_given && (ack_a_opcode == tlmh_pkg::A_PUT_FULL)) |=>
    (d_valid && !d_mismatch && (d_opcode == tlmh_pkg::D_ACK)))
    else $error("put answer misreported");
  get_ack_a: assert property (@(posedge clk_sys) disable iff (srst)
    (ack_valid && ce && !ack_data_given && (ack_a_opcode == tlmh_pkg::A_GET)) |=> d_mismatch)
    else $error("dataless get answer not flagged");
  payload_a: assert property (@(posedge clk_sys) disable iff (srst)
    mon_d_carries_payload == (mon_d_opcode == tlmh_pkg::D_ACK_DATA))
    else $error("d payload flag wrong");
  beats_a: assert property (@(posedge clk_sys) disable iff (srst)
    (mon_a_carries_payload && (mon_a_size == LG_BEAT + 4'h2)) |->
    ((mon_a_beat_total == CNT_W'(4)) && (mon_a_beat_total_minus_one == CNT_W'(3))))
    else $error("beat count wrong for four-beat message");
  ce_freeze_a: assert property (@(posedge clk_sys) disable iff (srst)
    !ce |=> $stable(st_r))
    else $error("state moved while clock enable low");

  function automatic logic carries(input logic [2:0] opc);
    return tlmh_pkg::a_has_data(opc);
  endfunction

  cv_legal_put: cover property (@(posedge clk_sys) disable iff (srst)
    a_valid && a_legal && (a_opcode == tlmh_pkg::A_PUT_PART));
  cv_hint_ack: cover property (@(posedge clk_sys) disable iff (srst)
    d_valid && (d_opcode == tlmh_pkg::D_HINT_ACK));
  cv_a_burst: cover property (@(posedge clk_sys) disable iff (srst)
    mon_a_done && (mon_a_count == CNT_W'(3)));
  cv_d_burst: cover property (@(posedge clk_sys) disable iff (srst)
    mon_d_done && !mon_d_first);
endmodule
`default_nettype wire

// ===== test/tlmh_mgr_model.sv
`timescale 1ns/1ns
`default_nettype none
module tlmh_mgr_model (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        a_valid,
  input  wire logic        a_legal,
  input  wire logic [2:0]  a_opcode,
  input  wire logic [2:0]  a_param,
  input  wire logic [3:0]  a_size,
  input  wire logic [3:0]  a_source,
  input  wire logic [63:0] a_data,
  output logic             ack_valid,
  output logic [2:0]       ack_a_opcode,
  output logic [3:0]       ack_a_size,
  output logic [3:0]       ack_a_source,
  output logic             ack_data_given,
  output logic [63:0]      ack_data
);
  // ==========================================================
  // one memory word; stored value is the left operand
  logic [63:0] mem_r, nv;
  logic [7:0]  beat_r;
  logic        lst;
  always_comb begin
    lst = (a_size > 4'h3) ? (beat_r + 8'h1 == 8'h1 << (a_size - 4'h3)) : 1'b1;
    case ({a_opcode == tlmh_pkg::A_LOGIC, a_param})
      4'h0: nv = ($signed(a_data) < $signed(mem_r)) ? a_data : mem_r;
      4'h1: nv = ($signed(a_data) > $signed(mem_r)) ? a_data : mem_r;
      4'h2: nv = (a_data < mem_r) ? a_data : mem_r;
      4'h3: nv = (a_data > mem_r) ? a_data : mem_r;
      4'h4: nv = mem_r + a_data;
      4'h8: nv = mem_r ^ a_data;
      4'h9: nv = mem_r | a_data;
      4'hA: nv = mem_r & a_data;
      default: nv = a_data;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    ack_valid <= 1'b0;
    if (srst) begin
      mem_r  <= '0;
      beat_r <= '0;
    end else if (a_valid && a_legal) begin
      ack_a_opcode   <= a_opcode;
      ack_a_size     <= a_size;
      ack_a_source   <= a_source;
      ack_data       <= mem_r;
      ack_data_given <= (a_opcode >= tlmh_pkg::A_ARITH) && (a_opcode <= tlmh_pkg::A_GET);
      if (a_opcode <= tlmh_pkg::A_PUT_PART) begin
        mem_r     <= a_data;
        ack_valid <= lst;
        beat_r    <= lst ? 8'h0 : beat_r + 8'h1;
      end else begin
        // not a cache: hints change nothing but still get an answer
        ack_valid <= 1'b1;
        if (a_opcode != tlmh_pkg::A_GET && a_opcode != tlmh_pkg::A_HINT) mem_r <= nv;
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/test_tlmh_edge_helper.sv
`timescale 1ns/1ns
`default_nettype none
module test_tlmh_edge_helper;
  localparam logic [63:0] NEG = 64'hFFFF_FFFF_FFFF_FFF0;
  logic        clk_sys, srst, ce, req_valid, req_mask_given, ack_valid, ack_data_given;
  logic        a_valid, a_legal, d_valid, d_mismatch, mon_a_valid, mon_a_ready, mon_d_valid, mon_d_ready;
  logic        mon_a_first, mon_a_last, mon_a_done, mon_a_carries_payload;
  logic        mon_d_first, mon_d_last, mon_d_done, mon_d_carries_payload;
  logic [2:0]  req_kind, req_param, ack_a_opcode, a_opcode, a_param, d_opcode, mon_a_opcode, mon_d_opcode;
  logic [3:0]  req_log2_size, a_size, ack_a_size, d_size, mon_a_size, mon_d_size;
  logic [3:0]  req_source_id, a_source, ack_a_source, d_source;
  logic [31:0] req_target_address, a_address;
  logic [63:0] req_data, a_data, ack_data, d_data, dcnt = '0;
  logic [7:0]  req_mask, a_mask, mon_a_count, mon_a_beat_total, mon_a_beat_total_minus_one;
  logic [7:0]  mon_d_count, mon_d_beat_total, mon_d_beat_total_minus_one;
  int          err_total = 0, samples_checked = 0;
  tlmh_edge_helper i_tlmh_edge_helper (.*);
  tlmh_mgr_model   i_tlmh_mgr_model (.*);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (d_valid === 1'b1) dcnt <= dcnt + 64'h1;
  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rq(input logic [2:0] k, input logic [3:0] sz, input logic [31:0] ad, input logic [63:0] dt,
                    input logic mg, input logic [2:0] pm);
    @(posedge clk_sys);
    req_valid          <= 1'b1;
    req_kind           <= k;
    req_source_id      <= {1'b1, k};
    req_target_address <= ad;
    req_log2_size      <= sz;
    req_data           <= dt;
    req_mask_given     <= mg;
    req_mask           <= dt[7:0];
    req_param          <= pm;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    #1;
    chk("a valid", 1'b1, a_valid);
  endtask
  task automatic wd;
    for (int n = 0; n < 8 && d_valid !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("d valid", 1'b1, d_valid);
    chk("d mismatch", 1'b0, d_mismatch);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_write;
    logic [63:0] c0;
    c0 = dcnt;
    rq(tlmh_pkg::REQ_PUT, 4'h4, 32'h10, 64'h1, 1'b0, 3'h0);
    rq(tlmh_pkg::REQ_PUT, 4'h4, 32'h10, 64'h2, 1'b0, 3'h0);
    chk("put opcode", tlmh_pkg::A_PUT_FULL, a_opcode);
    repeat (8) @(posedge clk_sys);
    #1;
    chk("ack count", 64'h1, dcnt - c0);
    chk("ack opcode", tlmh_pkg::D_ACK, d_opcode);
    rq(tlmh_pkg::REQ_PUT, 4'h3, 32'h8, 64'h10, 1'b1, 3'h0);
    chk("partial", {tlmh_pkg::A_PUT_PART, 8'h10, 32'h8}, {a_opcode, a_mask, a_address});
    wd;
    rq(tlmh_pkg::REQ_PUT, 4'h3, 32'h0, 64'h10, 1'b0, 3'h0);
    chk("full", {8'hFF, 4'h3}, {a_mask, a_size});
    wd;
    rq(tlmh_pkg::REQ_PUT, 4'h7, 32'h0, 64'h10, 1'b0, 3'h0);
    chk("oversize legal", 1'b0, a_legal);
    $display("test write done");
  endtask
  task automatic t_atomic;
    logic [63:0] ad [5] = '{NEG, 64'h20, NEG, NEG, 64'h20};
    logic [63:0] ap [5] = '{64'h10, NEG, 64'h20, 64'h20, NEG};
    logic [63:0] ld [4] = '{64'hF, 64'h20, 64'hF, 64'h77};
    logic [63:0] lp [4] = '{64'h10, 64'h1F, 64'h3F, 64'hF};
    for (int i = 0; i < 5; i++) begin
      rq(tlmh_pkg::REQ_ARITH, 4'h3, 32'h0, ad[i], 1'b0, 3'(i));
      chk("arith req", {tlmh_pkg::A_ARITH, 3'(i), 1'b1}, {a_opcode, a_param, a_legal});
      chk("arith operand", ad[i], a_data);
      wd;
      chk("arith prior", ap[i], d_data);
    end
    for (int i = 0; i < 4; i++) begin
      rq(tlmh_pkg::REQ_LOGIC, 4'h3, 32'h0, ld[i], 1'b0, 3'(i));
      chk("logic req", {tlmh_pkg::A_LOGIC, 3'(i), 1'b1}, {a_opcode, a_param, a_legal});
      wd;
      chk("logic prior", lp[i], d_data);
    end
    rq(tlmh_pkg::REQ_ARITH, 4'h3, 32'h0, 64'h0, 1'b0, 3'h5);
    chk("bad code legal", 1'b0, a_legal);
    rq(tlmh_pkg::REQ_GET, 4'h6, 32'h40, 64'h0, 1'b0, 3'h0);
    chk("get req", {tlmh_pkg::A_GET, 4'h6, 4'h8, 1'b1}, {a_opcode, a_size, a_source, a_legal});
    wd;
    chk("get opcode", {tlmh_pkg::D_ACK_DATA, 4'h6, 4'h8}, {d_opcode, d_size, d_source});
    chk("get data", 64'h77, d_data);
    for (int h = 0; h < 2; h++) begin
      rq(tlmh_pkg::REQ_HINT, 4'h6, 32'h0, 64'h0, 1'b0, 3'(h));
      chk("hint req", {tlmh_pkg::A_HINT, 3'(h)}, {a_opcode, a_param});
      wd;
      chk("hint answer", tlmh_pkg::D_HINT_ACK, d_opcode);
    end
    $display("test atomic and hint done");
  endtask
  task automatic t_track;
    for (int o = 0; o < 6; o++) begin
      @(posedge clk_sys);
      {mon_a_opcode, mon_a_size, mon_d_opcode, mon_d_size} <= {3'(o), 4'h4, 3'(o % 3), 4'h4};
      #1;
      chk("a payload", o < 4, mon_a_carries_payload);
      chk("a beats", {8'(1 + (o < 4)), 8'(o < 4)}, {mon_a_beat_total, mon_a_beat_total_minus_one});
      chk("d payload", {o % 3 == 1, 8'(1 + (o % 3 == 1))}, {mon_d_carries_payload, mon_d_beat_total});
    end
    @(posedge clk_sys);
    {mon_a_valid, mon_a_ready, mon_a_opcode, mon_a_size} <= {2'b10, tlmh_pkg::A_PUT_FULL, 4'h5};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      mon_a_ready <= 1'b1;
      #1;
      chk("a beat", {8'(i), 3'(i == 0 ? 3'b100 : 3'b000)}, {mon_a_count, mon_a_first, mon_a_last, mon_a_done});
    end
    @(posedge clk_sys);
    mon_a_ready <= 1'b0;
    #1;
    chk("stalled last", {8'h3, 3'b010}, {mon_a_count, mon_a_first, mon_a_last, mon_a_done});
    @(posedge clk_sys);
    {mon_a_ready, ce} <= 2'b10;
    #1;
    chk("final beat", 3'b011, {mon_a_first, mon_a_last, mon_a_done});
    @(posedge clk_sys);
    ce <= 1'b1;
    #1;
    chk("frozen", {8'h3, 1'b1}, {mon_a_count, mon_a_done});
    @(posedge clk_sys);
    mon_a_valid <= 1'b0;
    {mon_d_valid, mon_d_ready, mon_d_opcode} <= {2'b11, tlmh_pkg::D_ACK_DATA};
    #1;
    chk("wrapped", {8'h0, 1'b1}, {mon_a_count, mon_a_first});
    @(posedge clk_sys);
    srst <= 1'b1;
    #1;
    chk("d mid", {8'h1, 3'b011}, {mon_d_count, mon_d_first, mon_d_last, mon_d_done});
    @(posedge clk_sys);
    {srst, mon_d_valid} <= 2'b00;
    #1;
    chk("reset mid", {8'h0, 1'b1, 1'b0}, {mon_d_count, mon_d_first, d_valid});
    $display("test tracker done");
  endtask
  initial begin
    {req_valid, req_kind, req_source_id, req_target_address, req_log2_size, req_data, req_mask_given} = '0;
    {req_mask, req_param, mon_a_valid, mon_a_ready, mon_a_opcode, mon_a_size} = '0;
    {mon_d_valid, mon_d_ready, mon_d_opcode, mon_d_size} = '0;
    {srst, ce} = 2'b11;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    chk("after reset", {2'b00, 8'h0, 1'b1}, {a_valid, d_valid, mon_a_count, mon_a_first});
    t_write;
    t_atomic;
    t_track;
    wrap_up;
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    err_total++;
    wrap_up;
  end
endmodule
`default_nettype wire
